// file: core/pde2_entry_ctl.sv
`timescale 1ns/100ps
`include "pde2_params.svh"
// Contract
// [RULE_01] Execute is refused when no-exec is enabled and the entry blocks execute.
// [RULE_02] Ignored entry bits never influence translation or permission.
// [RULE_03] Reserved bits above the host width and bits 20..13 must be zero.
// [RULE_04] Page base is entry bits up to bit 21; low bits from input address.
// [RULE_05] With two-stage translation on, the base is a guest physical address.
// [RULE_06] Attribute, cache-disable, write-through select type; walker fetches write-back.
// [RULE_07] With tracking on, the device-used bit is set when the entry is used.
// [RULE_08] With tracking off, the device-used bit is neither read nor updated.
// [RULE_09] Global bit may be set by software but is never acted upon.
// [RULE_10] Page-size bit must be one for a 2MB mapping.
// [RULE_11] Dirty bit is set when a write through the mapping completes.
// [RULE_12] Accessed bit is set on the first access to the region.
// [RULE_13] User-level requests are refused when the user bit is zero.
// [RULE_14] Writes are refused when the write bit is zero.
// [RULE_15] Entry is used only when the present bit is one.
// [RULE_16] Host address width is 39 for client, 46 for server.
// [RULE_17] All requests are user level; no supervisor contexts exist.
// [RULE_18] Absent or reserved-bit entries give a fault instead of a mapping.
module pde2_entry_ctl import pde2_pkg::*; (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // AXI4-Lite write address and data
  input wire logic i_axi_awvalid,
  output logic o_axi_awready,
  input wire logic [`PDE2_AW-1:0] i_axi_awaddr,
  input wire logic i_axi_wvalid,
  output logic o_axi_wready,
  input wire logic [31:0] i_axi_wdata,
  input wire logic [3:0] i_axi_wstrb,
  // AXI4-Lite write response
  output logic o_axi_bvalid,
  input wire logic i_axi_bready,
  output logic [1:0] o_axi_bresp,
  // AXI4-Lite read
  input wire logic i_axi_arvalid,
  output logic o_axi_arready,
  input wire logic [`PDE2_AW-1:0] i_axi_araddr,
  output logic o_axi_rvalid,
  input wire logic i_axi_rready,
  output logic [31:0] o_axi_rdata,
  output logic [1:0] o_axi_rresp,
  // Walker side
  output logic o_busy,
  output logic o_wb_pending,
  output logic [1:0] o_fetch_mem_type
);
  pde2_state_t state_reg, state_next;

  logic aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg;
  logic [`PDE2_AW-1:0] awaddr_reg;
  logic [31:0] wdata_reg, rdata_reg;
  logic [3:0] wstrb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [5:0] ctrl_reg;
  logic [31:0] ent_lo_reg, ent_hi_reg, iaddr_reg, pa_lo_reg, pa_hi_reg;
  logic [31:0] ent_lo_next;
  logic req_wr_reg, req_ex_reg, valid_reg, wr_ok_reg, wb_pend_reg;
  logic fa_reg, fr_reg, fs_reg, du_reg, dw_reg, dx_reg, nest_reg;
  logic [2:0] mem_idx_reg;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic mapped(input logic [`PDE2_AW-1:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= `PDE2_OFF_PA_HI);
  endfunction : mapped

  // Bus channel readiness; one write and one read in flight
  assign o_axi_awready = ~aw_held_reg & ~bvalid_reg;
  assign o_axi_wready = ~w_held_reg & ~bvalid_reg;
  assign o_axi_arready = ~rvalid_reg;
  wire logic aw_take = i_axi_awvalid & o_axi_awready;
  wire logic w_take = i_axi_wvalid & o_axi_wready;
  wire logic ar_take = i_axi_arvalid & o_axi_arready;
  wire logic do_wr = aw_held_reg & w_held_reg & ~bvalid_reg;

  // Write decode
  wire logic wr_ctrl = do_wr & (awaddr_reg == `PDE2_OFF_CTRL);
  wire logic wr_lo = do_wr & (awaddr_reg == `PDE2_OFF_ENT_LO);
  wire logic wr_hi = do_wr & (awaddr_reg == `PDE2_OFF_ENT_HI);
  wire logic wr_ia = do_wr & (awaddr_reg == `PDE2_OFF_IADDR);
  wire logic wr_cmd = do_wr & (awaddr_reg == `PDE2_OFF_CMD) & wstrb_reg[0];
  wire logic go = wr_cmd & wdata_reg[`PDE2_K_GO] & (state_reg == PDE2_IDLE);
  wire logic wr_done = wr_cmd & wdata_reg[`PDE2_K_WR_DONE] & wr_ok_reg;
  wire logic wb_ack = wr_cmd & wdata_reg[`PDE2_K_WB_ACK];

  // Decode of the held entry
  logic fa_w, fr_w, fs_w, du_w, dw_w, dx_w, nest_w;
  logic [2:0] mem_w;
  logic [63:0] pa_w;
  pde2_decode u_dec (
    .i_entry({ent_hi_reg, ent_lo_reg}),
    .i_iaddr(iaddr_reg),
    .i_is_write(req_wr_reg),
    .i_is_exec(req_ex_reg),
    .i_no_exec_enable(ctrl_reg[`PDE2_C_NO_EXEC]),
    .i_two_stage_xlate_on(ctrl_reg[`PDE2_C_NEST]),
    .i_write_guard_super(ctrl_reg[`PDE2_C_WGS]),
    .i_server_cfg(ctrl_reg[`PDE2_C_SERVER]),
    .o_fault_absent(fa_w),
    .o_fault_rsvd(fr_w),
    .o_fault_size(fs_w),
    .o_deny_user(du_w),
    .o_deny_write(dw_w),
    .o_deny_exec(dx_w),
    .o_nested(nest_w),
    .o_mem_idx(mem_w),
    .o_pa(pa_w)
  );
  // Global bit is not looked at: no global treatment on this walker [RULE_09]
  wire logic fault_w = fa_w | fr_w | fs_w; // [RULE_18]
  wire logic use_ok = (state_reg == PDE2_CHECK) & ~fault_w & ~du_w & ~dw_w & ~dx_w;

  // Hardware flag setting
  logic [31:0] set_mask;
  pde2_flag_upd u_flag (
    .i_use(state_reg == PDE2_UPDATE),
    .i_track(ctrl_reg[`PDE2_C_TRACK]),
    .i_wr_done(wr_done),
    .o_set_mask(set_mask)
  );
  // Hardware set wins over a software write in the same cycle
  assign ent_lo_next = (wr_lo ? merge(ent_lo_reg, wdata_reg, wstrb_reg) : ent_lo_reg) | set_mask;
  wire logic flag_new = |(set_mask & ~ent_lo_reg);

  // Read mux
  wire logic [31:0] status_w = {16'h0, wr_ok_reg, wb_pend_reg, `PDE2_FETCH_WB, mem_idx_reg,
                                nest_reg, dx_reg, dw_reg, du_reg, fs_reg, fr_reg, fa_reg,
                                valid_reg, o_busy};
  wire logic [31:0] rd_mux =
    (i_axi_araddr == `PDE2_OFF_CTRL) ? {26'h0, ctrl_reg} :
    (i_axi_araddr == `PDE2_OFF_ENT_LO) ? ent_lo_reg :
    (i_axi_araddr == `PDE2_OFF_ENT_HI) ? ent_hi_reg :
    (i_axi_araddr == `PDE2_OFF_IADDR) ? iaddr_reg :
    (i_axi_araddr == `PDE2_OFF_STATUS) ? status_w :
    (i_axi_araddr == `PDE2_OFF_PA_LO) ? pa_lo_reg :
    (i_axi_araddr == `PDE2_OFF_PA_HI) ? pa_hi_reg : `PDE2_RST_WORD;

  // Walker sequence: faults end the walk without touching the entry
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      PDE2_IDLE: begin
        if (go) begin
          state_next = PDE2_CHECK;
        end
      end
      PDE2_CHECK: begin
        state_next = use_ok ? PDE2_UPDATE : PDE2_IDLE; // [RULE_15] [RULE_18]
      end
      PDE2_UPDATE: begin
        state_next = PDE2_IDLE;
      end
      default: begin
        state_next = PDE2_IDLE;
      end
    endcase
  end

  // Write address and data capture, either order
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= `PDE2_RST_WORD;
      wstrb_reg <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= i_axi_awaddr;
      end else if (do_wr) begin
        aw_held_reg <= 1'b0;
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        wdata_reg <= i_axi_wdata;
        wstrb_reg <= i_axi_wstrb;
      end else if (do_wr) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // Responses; unmapped addresses answer SLVERR
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `PDE2_RESP_OK;
      rvalid_reg <= 1'b0;
      rresp_reg <= `PDE2_RESP_OK;
      rdata_reg <= `PDE2_RST_WORD;
    end else begin
      if (do_wr) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= mapped(awaddr_reg) ? `PDE2_RESP_OK : `PDE2_RESP_SLVERR;
      end else if (i_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
      if (ar_take) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_mux;
        rresp_reg <= mapped(i_axi_araddr) ? `PDE2_RESP_OK : `PDE2_RESP_SLVERR;
      end else if (i_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // Software registers and the entry image
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_reg <= `PDE2_RST_CTRL;
      ent_lo_reg <= `PDE2_RST_WORD;
      ent_hi_reg <= `PDE2_RST_WORD;
      iaddr_reg <= `PDE2_RST_WORD;
      req_wr_reg <= 1'b0;
      req_ex_reg <= 1'b0;
    end else begin
      if (wr_ctrl & wstrb_reg[0]) begin
        ctrl_reg <= wdata_reg[5:0];
      end
      ent_lo_reg <= ent_lo_next; // [RULE_11] [RULE_12]
      if (wr_hi) begin
        ent_hi_reg <= merge(ent_hi_reg, wdata_reg, wstrb_reg);
      end
      if (wr_ia) begin
        iaddr_reg <= merge(iaddr_reg, wdata_reg, wstrb_reg);
      end
      if (go) begin
        req_wr_reg <= wdata_reg[`PDE2_K_WRITE];
        req_ex_reg <= wdata_reg[`PDE2_K_EXEC];
      end
    end
  end

  // Result capture at the check step
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      {fa_reg, fr_reg, fs_reg, du_reg, dw_reg, dx_reg, nest_reg} <= 7'h00;
      mem_idx_reg <= 3'h0;
      pa_lo_reg <= `PDE2_RST_WORD;
      pa_hi_reg <= `PDE2_RST_WORD;
      valid_reg <= 1'b0;
      wr_ok_reg <= 1'b0;
    end else if (state_reg == PDE2_CHECK) begin
      {fa_reg, fr_reg, fs_reg, du_reg, dw_reg, dx_reg, nest_reg} <=
        {fa_w, fr_w, fs_w, du_w, dw_w, dx_w, nest_w}; // [RULE_01] [RULE_13] [RULE_14]
      mem_idx_reg <= mem_w; // [RULE_06]
      pa_lo_reg <= pa_w[31:0]; // [RULE_04]
      pa_hi_reg <= pa_w[63:32];
      valid_reg <= use_ok;
      wr_ok_reg <= use_ok & req_wr_reg;
    end else if (go) begin
      valid_reg <= 1'b0;
      wr_ok_reg <= 1'b0;
    end
  end

  // State and write-back request; a new flag wins over the acknowledge
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= PDE2_IDLE;
      wb_pend_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (flag_new) begin
        wb_pend_reg <= 1'b1;
      end else if (wb_ack) begin
        wb_pend_reg <= 1'b0;
      end
    end
  end

  // Outputs
  assign o_axi_bvalid = bvalid_reg;
  assign o_axi_bresp = bresp_reg;
  assign o_axi_rvalid = rvalid_reg;
  assign o_axi_rdata = rdata_reg;
  assign o_axi_rresp = rresp_reg;
  assign o_busy = (state_reg != PDE2_IDLE);
  assign o_wb_pending = wb_pend_reg;
  assign o_fetch_mem_type = `PDE2_FETCH_WB; // [RULE_06]

  // Checks
  wire logic chk = (state_reg == PDE2_CHECK);
  AST_EXEC_BLOCK: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_01]
    chk && req_ex_reg && ctrl_reg[`PDE2_C_NO_EXEC] && ent_hi_reg[31] |=> dx_reg && !valid_reg)
    else $error("execute not refused");
  AST_IGNORED: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_02]
    chk && ent_lo_reg[20:13] == 8'h00 && ent_hi_reg[19:7] == 13'h0000 |=> !fr_reg)
    else $error("ignored bits raised a fault");
  AST_RSVD_LOW: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_03]
    chk && ent_lo_reg[20:13] != 8'h00 |=> fr_reg ##1 $stable(ent_lo_reg[5]))
    else $error("reserved bits accepted");
  AST_BASE: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_04]
    chk |=> pa_lo_reg[20:0] == $past(iaddr_reg[20:0]) && pa_lo_reg[31:21] == $past(ent_lo_reg[31:21]))
    else $error("page base wrong");
  AST_NESTED: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_05]
    chk |=> nest_reg == $past(ctrl_reg[`PDE2_C_NEST]))
    else $error("nested flag wrong");
  AST_MEMTYPE: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_06]
    chk |=> mem_idx_reg == {$past(ent_lo_reg[12]), $past(ent_lo_reg[4]), $past(ent_lo_reg[3])})
    else $error("memory type index wrong");
  AST_DEV_USED: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_07]
    use_ok && ctrl_reg[`PDE2_C_TRACK] |-> ##2 ent_lo_reg[10])
    else $error("device-used bit not set");
  AST_NO_TRACK: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_08]
    !ctrl_reg[`PDE2_C_TRACK] && !wr_lo |=> $stable(ent_lo_reg[10]))
    else $error("device-used bit changed while tracking off");
  AST_PSIZE: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_10]
    chk && !ent_lo_reg[7] |=> fs_reg && state_reg == PDE2_IDLE)
    else $error("small page accepted");
  AST_DIRTY: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_11]
    wr_done |=> ent_lo_reg[6] && (wb_pend_reg || $past(ent_lo_reg[6])))
    else $error("dirty bit not set");
  AST_ACCESSED: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_12]
    use_ok |=> state_reg == PDE2_UPDATE ##1 ent_lo_reg[5] && state_reg == PDE2_IDLE)
    else $error("accessed bit not set");
  AST_USER: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_13]
    chk && !ent_lo_reg[2] |=> du_reg && !valid_reg)
    else $error("user request not refused");
  AST_WRITE: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_14]
    chk && req_wr_reg && !ent_lo_reg[1] |=> dw_reg && !wr_ok_reg)
    else $error("write not refused");
  AST_PRESENT: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_15]
    chk && !ent_lo_reg[0] |=> fa_reg && state_reg == PDE2_IDLE)
    else $error("absent entry used");
  AST_HAW: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_16]
    chk && !ctrl_reg[`PDE2_C_SERVER] && ent_hi_reg[7] |=> fr_reg)
    else $error("client width not enforced");
  AST_FAULT: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_18]
    chk && fault_w |=> !valid_reg [*2])
    else $error("faulting entry reported valid");
  AST_BRESP: assert property (@(posedge i_clk) disable iff (i_rst)
    do_wr |=> o_axi_bvalid)
    else $error("write response missing");
  COV_GOOD: cover property (@(posedge i_clk) disable iff (i_rst) use_ok ##2 wr_done);
  COV_FAULT: cover property (@(posedge i_clk) disable iff (i_rst) chk && fault_w);
  COV_DENY: cover property (@(posedge i_clk) disable iff (i_rst) chk && !fault_w && du_w);
  COV_SLVERR: cover property (@(posedge i_clk) disable iff (i_rst)
    o_axi_rvalid && o_axi_rresp == `PDE2_RESP_SLVERR);
endmodule : pde2_entry_ctl

// file: inc/pde2_params.svh
`ifndef PDE2_PARAMS_SVH
`define PDE2_PARAMS_SVH

// Register byte offsets
`define PDE2_AW 8
`define PDE2_OFF_CTRL 8'h00
`define PDE2_OFF_ENT_LO 8'h04
`define PDE2_OFF_ENT_HI 8'h08
`define PDE2_OFF_IADDR 8'h0C
`define PDE2_OFF_CMD 8'h10
`define PDE2_OFF_STATUS 8'h14
`define PDE2_OFF_PA_LO 8'h18
`define PDE2_OFF_PA_HI 8'h1C

// Reset values
`define PDE2_RST_CTRL 6'h00
`define PDE2_RST_WORD 32'h00000000

// Entry field positions
`define PDE2_B_PRESENT 0
`define PDE2_B_WRITE 1
`define PDE2_B_USER 2
`define PDE2_B_WTHRU 3
`define PDE2_B_CDIS 4
`define PDE2_B_ACC 5
`define PDE2_B_DIRTY 6
`define PDE2_B_PSIZE 7
`define PDE2_B_DEV_USED 10
`define PDE2_B_ATTR 12
`define PDE2_B_RSV_LO 13
`define PDE2_B_RSV_HI 20
`define PDE2_B_BASE_LO 21
`define PDE2_B_RSV_TOP 51
`define PDE2_B_EXEC_BLK 63

// Host address widths
`define PDE2_HOST_WIDTH_CLIENT 39
`define PDE2_HOST_WIDTH_SERVER 46

// Control register fields
`define PDE2_C_NO_EXEC 0
`define PDE2_C_NEST 1
`define PDE2_C_TRACK 2
`define PDE2_C_GLOBAL 3
`define PDE2_C_WGS 4
`define PDE2_C_SERVER 5

// Command register fields
`define PDE2_K_GO 0
`define PDE2_K_WRITE 1
`define PDE2_K_EXEC 2
`define PDE2_K_WR_DONE 3
`define PDE2_K_WB_ACK 4

// Bus responses and walker fetch memory type
`define PDE2_RESP_OK 2'h0
`define PDE2_RESP_SLVERR 2'h2
`define PDE2_FETCH_WB 2'h3

`endif

// file: inc/pde2_pkg.sv
package pde2_pkg;
  // Walker sequence, Gray coded except the UPDATE to IDLE step
  typedef enum logic [1:0] {
    PDE2_IDLE = 2'b00,
    PDE2_CHECK = 2'b01,
    PDE2_UPDATE = 2'b11
  } pde2_state_t;
  typedef logic [63:0] pde2_entry_t;
endpackage : pde2_pkg

// file: core/pde2_decode.sv
`timescale 1ns/100ps
`include "pde2_params.svh"
module pde2_decode import pde2_pkg::*; (
  // Entry and request
  input wire pde2_entry_t i_entry,
  input wire logic [31:0] i_iaddr,
  input wire logic i_is_write,
  input wire logic i_is_exec,
  // Context controls
  input wire logic i_no_exec_enable,
  input wire logic i_two_stage_xlate_on,
  input wire logic i_write_guard_super,
  input wire logic i_server_cfg,
  // Results
  output logic o_fault_absent,
  output logic o_fault_rsvd,
  output logic o_fault_size,
  output logic o_deny_user,
  output logic o_deny_write,
  output logic o_deny_exec,
  output logic o_nested,
  output logic [2:0] o_mem_idx,
  output logic [63:0] o_pa
);
  // Every request is user level; no supervisor contexts exist
  localparam logic PRIV_USER = 1'b1; // [RULE_17]

  function automatic int host_width_of(input logic server);
    host_width_of = server ? `PDE2_HOST_WIDTH_SERVER : `PDE2_HOST_WIDTH_CLIENT; // [RULE_16]
  endfunction : host_width_of

  // Reserved bits; ignored bits never enter either mask
  function automatic logic [63:0] rsvd_mask(input int host_addr_width);
    logic [63:0] m;
    m = 64'h0;
    for (int i = 0; i < 64; i++) begin
      m[i] = (i >= host_addr_width && i <= `PDE2_B_RSV_TOP) ||
             (i >= `PDE2_B_RSV_LO && i <= `PDE2_B_RSV_HI);
    end
    return m;
  endfunction : rsvd_mask

  function automatic logic [63:0] base_mask(input int host_addr_width);
    logic [63:0] m;
    m = 64'h0;
    for (int i = 0; i < 64; i++) begin
      m[i] = (i >= `PDE2_B_BASE_LO) && (i < host_addr_width);
    end
    return m;
  endfunction : base_mask

  // Four-state net; a two-state int cannot be a net
  wire integer host_addr_width = host_width_of(i_server_cfg);

  // Structural checks
  assign o_fault_absent = ~i_entry[`PDE2_B_PRESENT]; // [RULE_15]
  assign o_fault_size = ~i_entry[`PDE2_B_PSIZE]; // [RULE_10]
  assign o_fault_rsvd = |(i_entry & rsvd_mask(host_addr_width)); // [RULE_02] [RULE_18]

  // Permissions
  assign o_deny_user = PRIV_USER & ~i_entry[`PDE2_B_USER]; // [RULE_13]
  assign o_deny_write = i_is_write & ~i_entry[`PDE2_B_WRITE] &
                        (PRIV_USER | i_write_guard_super); // [RULE_14]
  assign o_deny_exec = i_is_exec & i_no_exec_enable & i_entry[`PDE2_B_EXEC_BLK]; // [RULE_01]

  // Base plus page offset; nested means the base is still guest physical
  assign o_pa = (i_entry & base_mask(host_addr_width)) | {43'h0, i_iaddr[20:0]}; // [RULE_04]
  assign o_nested = i_two_stage_xlate_on; // [RULE_05]
  assign o_mem_idx = {i_entry[`PDE2_B_ATTR], i_entry[`PDE2_B_CDIS],
                      i_entry[`PDE2_B_WTHRU]}; // [RULE_06]
endmodule : pde2_decode

// file: core/pde2_flag_upd.sv
`timescale 1ns/100ps
`include "pde2_params.svh"
module pde2_flag_upd (
  // Events
  input wire logic i_use,
  input wire logic i_track,
  input wire logic i_wr_done,
  // Bits to set in the low entry word
  output logic [31:0] o_set_mask
);
  // Accessed on use, device-used only while tracking, dirty on good write
  wire logic [31:0] acc_set = i_use ? (32'h1 << `PDE2_B_ACC) : 32'h0; // [RULE_12]
  wire logic [31:0] used_set = (i_use & i_track) ? (32'h1 << `PDE2_B_DEV_USED) : 32'h0; // [RULE_07] [RULE_08]
  wire logic [31:0] d_set = i_wr_done ? (32'h1 << `PDE2_B_DIRTY) : 32'h0; // [RULE_11]
  assign o_set_mask = acc_set | used_set | d_set;
endmodule : pde2_flag_upd

// file: tb/pde2_mem_model.sv
`timescale 1ns/100ps
module pde2_mem_model import pde2_pkg::*; #(
  parameter logic [63:0] BASE_ADDR = 64'h0000_0012_3460_0000
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Write-back of the low entry word
  input wire logic i_wb_en,
  input wire logic [31:0] i_wb_lo,
  // Entry as held in memory
  output pde2_entry_t o_entry
);
  logic [31:0] lo_reg;
  // Entry left clear in reserved fields; present and 2MB size set
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      lo_reg <= BASE_ADDR[31:0] | 32'h0000_0087;
    end else if (i_wb_en) begin
      lo_reg <= i_wb_lo;
    end
  end
  // High word never rewritten, flags live in the low word
  assign o_entry = {BASE_ADDR[63:32], lo_reg};
endmodule : pde2_mem_model

// file: tb/test_pde_2mb_entry_handler.sv
`timescale 1ns/100ps
`include "pde2_params.svh"
module test_pde_2mb_entry_handler;
  typedef struct {logic [5:0] c; logic [63:0] f; logic [1:0] k; logic [11:0] st;} pde2_row_t;
  localparam logic [31:0] IADDR = 32'h001A_BCDE;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic awr, wr, arr, bvalid, rvalid, busy, wbp, wb_en = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, wb_lo = 32'h0, d, lo;
  logic [1:0] bresp, rresp, fetch, r;
  logic [63:0] ent, base, pa;
  int n_errors = 0;
  int n_compared = 0;
  pde2_row_t rows[16];

  always #10 i_clk = ~i_clk;

  pde2_entry_ctl i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_axi_awvalid(awv), .o_axi_awready(awr),
    .i_axi_awaddr(awaddr), .i_axi_wvalid(wv), .o_axi_wready(wr), .i_axi_wdata(wdata),
    .i_axi_wstrb(4'hF), .o_axi_bvalid(bvalid), .i_axi_bready(bready), .o_axi_bresp(bresp),
    .i_axi_arvalid(arv), .o_axi_arready(arr), .i_axi_araddr(araddr), .o_axi_rvalid(rvalid),
    .i_axi_rready(rready), .o_axi_rdata(rdata), .o_axi_rresp(rresp), .o_busy(busy),
    .o_wb_pending(wbp), .o_fetch_mem_type(fetch));
  pde2_mem_model u_mem (.i_clk(i_clk), .i_rst(i_rst), .i_wb_en(wb_en), .i_wb_lo(wb_lo),
    .o_entry(base));

  task automatic chk(input string nm, input logic [63:0] ex, input logic [63:0] got);
    n_compared++;
    if (got !== ex) begin
      $display("mismatch %s expected %h seen %h", nm, ex, got);
      n_errors++;
    end
  endtask : chk

  // Write: address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] dt, output logic [1:0] rs);
    @(posedge i_clk);
    awaddr <= a;
    wdata <= dt;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    // No cycle count assumed; only the watchdog ends a stuck wait
    do begin
      @(posedge i_clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] dt, output logic [1:0] rs);
    @(posedge i_clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (arv && arr) arv <= 1'b0;
    end while (rvalid !== 1'b1);
    dt = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  // Load context, entry and address, start, then wait out the walker
  task automatic walk(input logic [5:0] c, input logic [63:0] e, input logic [1:0] k);
    int n;
    axi_wr(`PDE2_OFF_CTRL, {26'h0, c}, r);
    axi_wr(`PDE2_OFF_ENT_LO, e[31:0], r);
    axi_wr(`PDE2_OFF_ENT_HI, e[63:32], r);
    axi_wr(`PDE2_OFF_IADDR, IADDR, r);
    axi_wr(`PDE2_OFF_CMD, {29'h0, k, 1'b1}, r);
    n = 0;
    while (busy !== 1'b0 && n < 20) begin
      @(posedge i_clk);
      n++;
    end
    chk("busy", 64'h0, 64'(busy));
  endtask : walk

  task automatic end_of_test();
    if (n_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  // Cut a hang short, about thirty times the expected run
  initial begin
    repeat (20000) @(posedge i_clk);
    n_errors++;
    end_of_test();
  end

  initial begin
    rows = '{'{6'h00, 64'h0, 2'h0, 12'h002}, '{6'h00, 64'h0, 2'h1, 12'h002},
      '{6'h00, 64'h1, 2'h0, 12'h004}, '{6'h00, 64'h80, 2'h0, 12'h010},
      '{6'h00, 64'h2000, 2'h0, 12'h008}, '{6'h00, 64'h80_0000_0000, 2'h0, 12'h008},
      '{6'h20, 64'h80_0000_0000, 2'h0, 12'h002}, '{6'h00, 64'h4, 2'h0, 12'h020},
      '{6'h10, 64'h2, 2'h1, 12'h040}, '{6'h00, 64'h2, 2'h0, 12'h002},
      '{6'h01, 64'h8000_0000_0000_0000, 2'h2, 12'h080},
      '{6'h00, 64'h8000_0000_0000_0000, 2'h2, 12'h002},
      '{6'h02, 64'h0, 2'h0, 12'h102}, '{6'h00, 64'h1008, 2'h0, 12'hA02},
      '{6'h08, 64'h7FF0_0000_0000_0B00, 2'h0, 12'h002}, '{6'h04, 64'h0, 2'h0, 12'h002}};
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    // Ordinary walks, one row each
    foreach (rows[i]) begin
      ent = base ^ rows[i].f;
      walk(rows[i].c, ent, rows[i].k);
      axi_rd(`PDE2_OFF_STATUS, d, r);
      chk("status", 64'(rows[i].st), 64'(d & 32'h0FFE));
      lo = rows[i].st[1] ? (ent[31:0] | 32'h20 | (rows[i].c[2] ? 32'h400 : 32'h0)) : ent[31:0];
      axi_rd(`PDE2_OFF_ENT_LO, d, r);
      chk("entry_lo", 64'(lo), 64'(d));
      if (rows[i].st[1]) begin
        pa = (ent & ((64'h1 << (rows[i].c[5] ? 46 : 39)) - 64'h1) & ~64'h1F_FFFF) | IADDR[20:0];
        axi_rd(`PDE2_OFF_PA_LO, d, r);
        chk("pa_lo", 64'(pa[31:0]), 64'(d));
        axi_rd(`PDE2_OFF_PA_HI, d, r);
        chk("pa_hi", 64'(pa[63:32]), 64'(d));
      end
      axi_wr(`PDE2_OFF_CMD, 32'h10, r);
    end
    // Write completes: dirty set, write-back to memory, then a reuse changes nothing
    walk(6'h00, base, 2'h1);
    axi_rd(`PDE2_OFF_STATUS, d, r);
    chk("wb_write_ok", 64'hC000, 64'(d & 32'hC000));
    axi_wr(`PDE2_OFF_CMD, 32'h08, r);
    axi_rd(`PDE2_OFF_ENT_LO, d, r);
    chk("dirty", 64'(base[31:0] | 32'h60), 64'(d));
    wb_lo <= d;
    wb_en <= 1'b1;
    @(posedge i_clk);
    wb_en <= 1'b0;
    axi_wr(`PDE2_OFF_CMD, 32'h10, r);
    chk("wb_ack", 64'h0, 64'(wbp));
    walk(6'h00, base, 2'h0);
    chk("wb_again", 64'h0, 64'(wbp));
    // Completion after a faulting walk leaves the entry alone
    walk(6'h00, 64'h0000_0012_3460_0086, 2'h1);
    axi_wr(`PDE2_OFF_CMD, 32'h08, r);
    axi_rd(`PDE2_OFF_ENT_LO, d, r);
    chk("no_dirty", 64'h3460_0086, 64'(d));
    // Unmapped and read-only places
    axi_rd(8'h20, d, r);
    chk("unmapped_rd", 64'h2_0000_0000, {30'h0, r, d});
    axi_wr(8'h20, 32'h1, r);
    chk("unmapped_wr", 64'(`PDE2_RESP_SLVERR), 64'(r));
    axi_wr(`PDE2_OFF_STATUS, 32'hFFFF_FFFF, r);
    chk("ro_wr", 64'(`PDE2_RESP_OK), 64'(r));
    // Second reset in mid-run, then reset values
    i_rst <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    axi_rd(`PDE2_OFF_STATUS, d, r);
    chk("status_rst", 64'h3000, 64'(d));
    chk("fetch", 64'(`PDE2_FETCH_WB), 64'(fetch));
    axi_rd(`PDE2_OFF_ENT_LO, d, r);
    chk("entry_rst", 64'h0, 64'(d));
    axi_rd(`PDE2_OFF_CTRL, d, r);
    chk("ctrl_rst", 64'h0, 64'(d));
    end_of_test();
  end
endmodule : test_pde_2mb_entry_handler
